/* File: src/voltage_reference_control.sv */
// APB slave holding the voltage reference control register and its analog controls
// Contract
// - The comparator/DAC gain field turns its output off at code zero and selects 1x, 2x or 4x.
// - The ADC gain field uses the same encoding: zero off, then 1x, 2x and 4x.
// - On variants with an internal regulator the ready flag always reads one.
// - The temperature range bit selects the high range when set and the low range when clear.
// - Bits from 7 down are enable, ready, temp enable, temp range, comparator gain, ADC gain.
`timescale 1ns/100ps
`include "voltage_reference_control_regs.svh"

module voltage_reference_control #(
  parameter bit HAS_LDO = 1'b0,
  parameter int SETTLE_CYCLES = `VREF_SETTLE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reference_settled,
  output voltage_reference_pkg::analog_ctrl_s analog_ctrl
);

  localparam int CW = $clog2(SETTLE_CYCLES + 1);

  logic reference_enable;
  logic temp_indicator_enable;
  logic temp_range_select;
  voltage_reference_pkg::gain_e comparator_dac_gain;
  voltage_reference_pkg::gain_e adc_reference_gain;
  logic [CW-1:0] settle_count;
  logic settled;
  logic ready;
  voltage_reference_pkg::control_s ctrl_view;
  logic sel_ctrl;
  logic sel_status;
  logic wr_ctrl;
  logic [`VREF_ADDR_BITS-1:0] addr;

  assign addr = paddr[`VREF_ADDR_BITS-1:0];
  assign sel_ctrl = (addr == `VREF_CTRL_OFFSET);
  assign sel_status = (addr == `VREF_STATUS_OFFSET);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(sel_ctrl || (sel_status && !pwrite));
  assign wr_ctrl = clk_en && psel && penable && pwrite && sel_ctrl && pstrb[0];

  // Read-only flag bit is excluded from the write mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_enable <= 1'b0;
      temp_indicator_enable <= 1'b0;
      temp_range_select <= 1'b0;
      comparator_dac_gain <= voltage_reference_pkg::gain_off;
      adc_reference_gain <= voltage_reference_pkg::gain_off;
    end else if (wr_ctrl) begin
      reference_enable <= pwdata[`VREF_ENABLE_BIT];
      temp_indicator_enable <= pwdata[`VREF_TEMP_EN_BIT];
      temp_range_select <= pwdata[`VREF_TEMP_RANGE_BIT];
      comparator_dac_gain <= voltage_reference_pkg::gain_e'(pwdata[`VREF_CDAC_GAIN_LSB +: 2]);
      adc_reference_gain <= voltage_reference_pkg::gain_e'(pwdata[`VREF_ADC_GAIN_LSB +: 2]);
    end
  end

  // Settling timer restarts whenever the reference is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_count <= '0;
    end else if (clk_en) begin
      if (!reference_enable) begin
        settle_count <= '0;
      end else if (settle_count != CW'(SETTLE_CYCLES)) begin
        settle_count <= settle_count + CW'(1);
      end
    end
  end

  assign settled = (settle_count == CW'(SETTLE_CYCLES)) && reference_settled;
  assign ready = HAS_LDO ? 1'b1 : (reference_enable && settled);

  always_comb begin
    ctrl_view.reference_enable = reference_enable;
    ctrl_view.reference_ready_flag = ready;
    ctrl_view.temp_indicator_enable = temp_indicator_enable;
    ctrl_view.temp_range_select = temp_range_select;
    ctrl_view.comparator_dac_gain = comparator_dac_gain;
    ctrl_view.adc_reference_gain = adc_reference_gain;
  end

  // Read data registered on the setup cycle so it is valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      if (sel_ctrl) begin
        prdata <= {24'h000000, ctrl_view};
      end else if (sel_status) begin
        prdata <= {30'h00000000, settled, ready};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  function automatic logic [2:0] scale_of(input voltage_reference_pkg::gain_e g);
    unique case (g)
      voltage_reference_pkg::gain_off: scale_of = 3'h0;
      voltage_reference_pkg::gain_1x: scale_of = 3'h1;
      voltage_reference_pkg::gain_2x: scale_of = 3'h2;
      voltage_reference_pkg::gain_4x: scale_of = 3'h4;
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_ctrl <= '0;
    end else if (clk_en) begin
      analog_ctrl.reference_on <= reference_enable;
      analog_ctrl.comparator_dac_on <= comparator_dac_gain != voltage_reference_pkg::gain_off;
      analog_ctrl.comparator_dac_scale <= scale_of(comparator_dac_gain);
      analog_ctrl.adc_on <= adc_reference_gain != voltage_reference_pkg::gain_off;
      analog_ctrl.adc_scale <= scale_of(adc_reference_gain);
      analog_ctrl.temp_on <= temp_indicator_enable;
      analog_ctrl.temp_high_range <= temp_range_select;
    end
  end

endmodule

/* File: src/voltage_reference_control_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef VOLTAGE_REFERENCE_CONTROL_REGS_SVH
`define VOLTAGE_REFERENCE_CONTROL_REGS_SVH

`define VREF_CTRL_OFFSET 12'h000
`define VREF_STATUS_OFFSET 12'h004
`define VREF_ADDR_BITS 12
`define VREF_CTRL_RESET 8'h00
`define VREF_ENABLE_BIT 7
`define VREF_READY_BIT 6
`define VREF_TEMP_EN_BIT 5
`define VREF_TEMP_RANGE_BIT 4
`define VREF_CDAC_GAIN_LSB 2
`define VREF_ADC_GAIN_LSB 0
`define VREF_WRITE_MASK 8'hBF
`define VREF_SETTLE_NS 25000
`define VREF_CLK_NS 10
`define VREF_SETTLE_CYCLES ((`VREF_SETTLE_NS + `VREF_CLK_NS - 1) / `VREF_CLK_NS)

`endif

/* File: src/voltage_reference_pkg.sv */
// Types shared by the voltage reference control block
package voltage_reference_pkg;

  typedef enum logic [1:0] {
    gain_off = 2'b00,
    gain_1x = 2'b01,
    gain_2x = 2'b10,
    gain_4x = 2'b11
  } gain_e;

  typedef struct packed {
    logic reference_enable;
    logic reference_ready_flag;
    logic temp_indicator_enable;
    logic temp_range_select;
    gain_e comparator_dac_gain;
    gain_e adc_reference_gain;
  } control_s;

  typedef struct packed {
    logic comparator_dac_on;
    logic [2:0] comparator_dac_scale;
    logic adc_on;
    logic [2:0] adc_scale;
    logic temp_on;
    logic temp_high_range;
    logic reference_on;
  } analog_ctrl_s;

endpackage

/* File: bench/vref_properties.sv */
// Assertions on the voltage reference control ports
`timescale 1ns/100ps
module vref_properties #(parameter bit HAS_LDO = 1'b0) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input voltage_reference_pkg::analog_ctrl_s analog_ctrl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [7:0] w = pwdata[7:0];
  function automatic logic [2:0] sc(logic [1:0] c);
    return {&c, c == 2'h2, c == 2'h1};
  endfunction
  sequence wr;
    psel && penable && pwrite && clk_en && pstrb[0] && paddr[11:0] == 12'h000;
  endsequence
  sequence rd;
    psel && !penable && !pwrite && clk_en && paddr[11:0] == 12'h000;
  endsequence
  a_cdac_gain: assert property (wr |-> ##2 analog_ctrl[10:7] ==
    {|$past(w[3:2], 2), sc($past(w[3:2], 2))}) else $error("comparator gain wrong");
  a_adc_gain: assert property (wr |-> ##2 analog_ctrl[6:3] ==
    {|$past(w[1:0], 2), sc($past(w[1:0], 2))}) else $error("adc gain wrong");
  a_temp_range: assert property (wr |-> ##2 analog_ctrl[2:1] == $past(w[5:4], 2))
    else $error("temperature controls wrong");
  a_enable_bit: assert property (wr |-> ##2 analog_ctrl.reference_on == $past(w[7], 2))
    else $error("enable wrong");
  a_ready_read: assert property (rd |=> !prdata[6] || HAS_LDO || prdata[7])
    else $error("ready while disabled");
  a_ldo_ready: assert property (rd |=> !HAS_LDO || prdata[6])
    else $error("ready low on regulator variant");
  a_upper_zero: assert property (rd |=> prdata[31:8] == 24'h0)
    else $error("upper bits set");
endmodule

/* File: bench/voltage_reference_control_bench.sv */
// Bench for the voltage reference control register
`timescale 1ns/100ps
module voltage_reference_control_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic settled = 1'b0, serr, pready, pslverr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, q, prdata;
  logic clk_en = 1'b1;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata_ldo;
  voltage_reference_pkg::analog_ctrl_s ac;
  int n_errors = 0, check_count = 0;
  voltage_reference_control #(.SETTLE_CYCLES(8)) u_voltage_reference_control (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reference_settled(settled), .analog_ctrl(ac));
  // Regulator variant shares the bus; only its read data is watched
  voltage_reference_control #(.HAS_LDO(1'b1), .SETTLE_CYCLES(8))
    u_voltage_reference_control_ldo (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_ldo), .pready(),
    .pslverr(), .reference_settled(settled), .analog_ctrl());
  initial forever #5 pclk = ~pclk;
  function automatic logic [2:0] sc(logic [1:0] c);
    return {&c, c == 2'h2, c == 2'h1};
  endfunction
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Leaves psel high so a following call is a back-to-back setup
  task automatic xfer(input logic wr, input logic [31:0] a, d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    serr = pslverr;
    penable <= 1'b0;
    if (i == 20) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic t_fields;
    for (int c = 0; c < 4; c++) begin
      logic [1:0] g;
      logic [7:0] v;
      g = 2'(c);
      v = {2'b0, g[0], g[1], g, ~g};
      xfer(1'b1, 32'h0, {24'h0, v});
      xfer(1'b0, 32'h0, 32'h0);
      chk(q, {24'h0, v});
      chk({21'h0, ac}, {21'h0, |g, sc(g), |(~g), sc(~g), g[0], g[1], 1'b0});
    end
  endtask
  task automatic t_ready;
    xfer(1'b1, 32'h0, 32'hC0);
    psel <= 1'b0;
    repeat (12) @(posedge pclk);
    xfer(1'b0, 32'h0, 32'h0);
    chk(q, 32'h80);
    settled <= 1'b1;
    xfer(1'b0, 32'h0, 32'h0);
    chk(q, 32'hC0);
    chk({31'h0, ac.reference_on}, 32'h1);
    xfer(1'b1, 32'h0, 32'h40);
    xfer(1'b0, 32'h0, 32'h0);
    chk(q, 32'h0);
    xfer(1'b0, 32'h8, 32'h0);
    chk({q[30:0], serr}, 32'h1);
  endtask
  task automatic t_gates;
    pstrb <= 4'hE;
    xfer(1'b1, 32'h0, 32'h3F);
    pstrb <= 4'hF;
    clk_en <= 1'b0;
    xfer(1'b1, 32'h0, 32'h3F);
    clk_en <= 1'b1;
    xfer(1'b0, 32'h0, 32'h0);
    chk(q, 32'h0);
    chk({21'h0, ac}, 32'h0);
    xfer(1'b1, 32'h0, 32'h80);
    psel <= 1'b0;
    repeat (12) @(posedge pclk);
    xfer(1'b0, 32'h4, 32'h0);
    chk({q[30:0], serr}, 32'h6);
    xfer(1'b1, 32'h4, 32'h0);
    chk({31'h0, serr}, 32'h1);
    psel <= 1'b0;
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 32'h0, 32'h0);
    chk(q, 32'h0);
    chk({21'h0, ac}, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 32'h0, 32'h0);
    chk(q, 32'h0);
    chk(prdata_ldo, 32'h40);
    t_fields();
    t_ready();
    t_gates();
    end_of_test();
  end
endmodule
bind voltage_reference_control vref_properties #(.HAS_LDO(HAS_LDO)) u_vref_properties (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .analog_ctrl(analog_ctrl));
